// ### logic/ext_irq_sampler.sv
// One external interrupt pin: synchroniser, machine-cycle sampling, flag
`timescale 1ns/1ns
module ext_irq_sampler
(
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic clk_en_i,
    // Sampling
    input wire logic mc_tick_i,
    input wire logic pin_n_i,
    input wire logic edge_sel_i,
    input wire logic clear_i,
    // Result
    output logic flag_o,
    output logic set_o
);

    logic sync1_ff;
    logic sync2_ff;
    logic sample_ff;
    logic flag_ff;
    logic nxt_flag;

    // Previous sample resets high so reset release gives no false edge
    always_ff @(posedge ref_clk_i)
    begin
        if (!rst_n_i)
        begin
            sync1_ff <= 1'b1;
            sync2_ff <= 1'b1;
            sample_ff <= 1'b1;
            flag_ff <= 1'b0;
        end
        else if (clk_en_i)
        begin
            sync1_ff <= pin_n_i;
            sync2_ff <= sync1_ff;
            if (mc_tick_i)
                sample_ff <= sync2_ff;
            flag_ff <= nxt_flag;
        end
    end

    assign set_o = edge_sel_i && mc_tick_i && sample_ff && !sync2_ff; // [RL12]

    // Edge: a new edge wins over the clear; level: track the pin
    always_comb
    begin
        nxt_flag = flag_ff;
        if (edge_sel_i)
            nxt_flag = set_o || (flag_ff && !clear_i); // [RL12] [RL15]
        else if (mc_tick_i)
            nxt_flag = !sync2_ff; // [RL11] [RL17]
    end

    assign flag_o = flag_ff;

    // ********************************
    // Assertions
    // ********************************
    AST_LEVEL_TRACK: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // [RL11]
        (clk_en_i && mc_tick_i && !edge_sel_i) |=> (flag_o == !$past(sync2_ff)))
        else $error("level mode flag does not follow pin sample");

    AST_EDGE_SET: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // [RL12]
        (clk_en_i && edge_sel_i && mc_tick_i && sample_ff && !sync2_ff) |=> flag_o)
        else $error("falling edge between samples did not set flag");

endmodule : ext_irq_sampler

// ### logic/four_level_interrupt_controller.sv
// Four-level interrupt controller with twelve sources and vectoring
//
// What this block does
// RL1: Twelve sources, each gated by its own enable bit.
// RL2: Global enable low blocks every source.
// RL3: Each source gets one of four levels from a low and high bit.
// RL4: A running handler yields only to a strictly higher level.
// RL5: A handler at the top level is never preempted.
// RL6: Simultaneous requests of different levels: higher level served first.
// RL7: Same-level ties follow a fixed ranking, external 0 highest.
// RL8: Each source has its own fixed vector address.
// RL9: Enable and priority bits sit at fixed positions in two registers.
// RL10: Only externals, brownout, keypad, comparators, watchdog wake power-down.
// RL11: Level mode raises the external request while the pin samples low.
// RL12: Edge mode sets the flag on a high sample then a low sample.
// RL13: Pin levels must hold at least six CPU clocks.
// RL14: Edge mode needs one machine cycle high then one low.
// RL15: Edge flag clears by hardware when its vector is taken.
// RL16: Level source holds its request until the interrupt is taken.
// RL17: Level flag tracks the pin; still low after return re-requests.
// RL18: Enabled external request wakes the part from idle or power-down.
// RL19: Serial transmit or receive forms one request; bus timer has no flag.
// RL20: Level is high bit then low bit; three highest, zero lowest.
`timescale 1ns/1ns
module four_level_interrupt_controller
(
    // Clock, reset, enable
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic clk_en_i,
    // Enable and priority registers
    input wire logic [7:0] irq_enable_reg_a_i,
    input wire logic [7:0] irq_enable_reg_b_i,
    input wire logic [7:0] prio_low_reg_a_i,
    input wire logic [7:0] prio_high_reg_a_i,
    input wire logic [7:0] prio_low_reg_b_i,
    input wire logic [7:0] prio_high_reg_b_i,
    input wire logic ext0_edge_select_i,
    input wire logic ext1_edge_select_i,
    // External pins, active low
    input wire logic [1:0] ext_irq_pin_n_i,
    // Peripheral request flags
    input wire logic timer0_overflow_flag_i,
    input wire logic timer1_overflow_flag_i,
    input wire logic serial_tx_done_flag_i,
    input wire logic serial_rx_done_flag_i,
    input wire logic brownout_flag_i,
    input wire logic twowire_attention_flag_i,
    input wire logic keypad_flag_i,
    input wire logic comparator1_flag_i,
    input wire logic comparator2_flag_i,
    input wire logic watchdog_overflow_flag_i,
    input wire logic bus_timer_req_i,
    // Processor handshake
    input wire logic irq_ack_i,
    input wire logic irq_return_i,
    output logic irq_req_o,
    output logic [15:0] irq_vector_o,
    output logic [1:0] irq_level_o,
    // Power modes
    input wire logic idle_i,
    input wire logic power_down_i,
    output logic wake_o,
    // Status
    output logic ext0_request_flag_o,
    output logic ext1_request_flag_o,
    output logic [3:0] in_service_o
);

    // ********************************
    // Decoding helpers
    // ********************************
    // Winner: {valid, level, index}; ranking loop keeps earlier on ties
    function automatic logic [6:0] pick_winner(
        input logic [11:0] req,
        input logic [23:0] lvl
    );
        logic found;
        logic [1:0] best_lvl;
        logic [3:0] best_idx;
        logic [3:0] s;
        found = 1'b0;
        best_lvl = 2'h0;
        best_idx = 4'h0;
        for (int r = 0; r < irq_pkg::NUM_SRC; r++)
        begin
            s = irq_pkg::RANK_ORDER[r];
            if (req[s] && (!found || lvl[2*s +: 2] > best_lvl)) // [RL6] [RL7]
            begin
                found = 1'b1;
                best_lvl = lvl[2*s +: 2];
                best_idx = s;
            end
        end
        return {found, best_lvl, best_idx};
    endfunction : pick_winner

    // Highest level in service: {any, level}
    function automatic logic [2:0] top_level(input logic [3:0] isv);
        logic [2:0] res;
        res = 3'h0;
        for (int l = 0; l < irq_pkg::NUM_LVL; l++)
        begin
            if (isv[l])
                res = {1'b1, 2'(l)};
        end
        return res;
    endfunction : top_level

    // ********************************
    // Machine cycle timing
    // ********************************
    logic [2:0] mc_cnt_ff;
    logic [2:0] nxt_mc_cnt;
    wire mc_tick = (mc_cnt_ff == irq_pkg::MC_CNT_LAST);

    // Pins are sampled once per machine cycle, hence the pin hold times
    assign nxt_mc_cnt = mc_tick ? irq_pkg::MC_CNT_RST : mc_cnt_ff + 3'h1; // [RL13] [RL14]

    always_ff @(posedge ref_clk_i)
    begin
        if (!rst_n_i)
            mc_cnt_ff <= irq_pkg::MC_CNT_RST;
        else if (clk_en_i)
            mc_cnt_ff <= nxt_mc_cnt;
    end

    // ********************************
    // Offer state and registers
    // ********************************
    irq_pkg::offer_state_e state_ff;
    irq_pkg::offer_state_e nxt_state;
    logic [3:0] src_ff;
    logic [1:0] lvl_ff;
    logic [15:0] vec_ff;
    logic [3:0] isv_ff;
    logic [3:0] nxt_isv;
    logic wake_ff;
    logic [11:0] hold_req_ff;

    wire take = (state_ff == irq_pkg::ST_OFFER) && irq_ack_i;

    // ********************************
    // External inputs
    // ********************************
    wire [1:0] ext_flag;
    wire [1:0] ext_set;
    wire [1:0] ext_edge = {ext1_edge_select_i, ext0_edge_select_i};

    generate
        for (genvar e = 0; e < 2; e++)
        begin : g_ext
            // Level-mode flags ignore the clear; the pin owner holds it
            wire clr = take && (src_ff == 4'(2 * e)); // [RL15] [RL16]
            ext_irq_sampler u_sampler
            (
                .ref_clk_i(ref_clk_i),
                .rst_n_i(rst_n_i),
                .clk_en_i(clk_en_i),
                .mc_tick_i(mc_tick),
                .pin_n_i(ext_irq_pin_n_i[e]),
                .edge_sel_i(ext_edge[e]),
                .clear_i(clr),
                .flag_o(ext_flag[e]),
                .set_o(ext_set[e])
            );
        end
    endgenerate

    // ********************************
    // Source requests and levels
    // ********************************
    wire [11:0] src_flag;
    wire [15:0] en_bits = {irq_enable_reg_b_i, irq_enable_reg_a_i};
    wire [15:0] pl_bits = {prio_low_reg_b_i, prio_low_reg_a_i};
    wire [15:0] ph_bits = {prio_high_reg_b_i, prio_high_reg_a_i};
    wire global_irq_enable = irq_enable_reg_a_i[irq_pkg::GLOBAL_EN_BIT];
    wire [11:0] enabled_req;
    wire [23:0] src_lvl;

    assign src_flag[irq_pkg::SRC_EXT0] = ext_flag[0];
    assign src_flag[irq_pkg::SRC_TMR0] = timer0_overflow_flag_i;
    assign src_flag[irq_pkg::SRC_EXT1] = ext_flag[1];
    assign src_flag[irq_pkg::SRC_TMR1] = timer1_overflow_flag_i;
    // One shared request for both serial directions
    assign src_flag[irq_pkg::SRC_SER] = serial_tx_done_flag_i || serial_rx_done_flag_i; // [RL19]
    assign src_flag[irq_pkg::SRC_BO] = brownout_flag_i;
    assign src_flag[irq_pkg::SRC_TWI] = twowire_attention_flag_i;
    assign src_flag[irq_pkg::SRC_KB] = keypad_flag_i;
    assign src_flag[irq_pkg::SRC_CMP2] = comparator2_flag_i;
    assign src_flag[irq_pkg::SRC_WD] = watchdog_overflow_flag_i;
    assign src_flag[irq_pkg::SRC_CMP1] = comparator1_flag_i;
    // Bus timer request is internal only, never a visible flag
    assign src_flag[irq_pkg::SRC_BTMR] = bus_timer_req_i; // [RL19]

    generate
        for (genvar i = 0; i < irq_pkg::NUM_SRC; i++)
        begin : g_src
            assign enabled_req[i] = src_flag[i] && en_bits[irq_pkg::SRC_BIT[i]]; // [RL1] [RL9]
            assign src_lvl[2*i +: 2] = {ph_bits[irq_pkg::SRC_BIT[i]],
                                        pl_bits[irq_pkg::SRC_BIT[i]]}; // [RL3] [RL20]
        end
    endgenerate

    // ********************************
    // Arbitration
    // ********************************
    wire [11:0] pending = enabled_req & {12{global_irq_enable}}; // [RL2]
    wire [6:0] winner = pick_winner(pending, src_lvl);
    wire win_valid = winner[6];
    wire [1:0] win_lvl = winner[5:4];
    wire [3:0] win_idx = winner[3:0];
    wire [2:0] isv_top = top_level(isv_ff);
    wire isv_any = isv_top[2];
    wire [1:0] isv_lvl = isv_top[1:0];
    // Top level can never be exceeded, so it is never preempted
    wire allowed = win_valid && (!isv_any || win_lvl > isv_lvl); // [RL4] [RL5]

    always_comb
    begin
        nxt_state = state_ff;
        unique case (state_ff)
            irq_pkg::ST_IDLE:
                nxt_state = allowed ? irq_pkg::ST_OFFER : irq_pkg::ST_IDLE;
            irq_pkg::ST_OFFER:
                // One idle cycle after a take lets flags and in-service settle
                nxt_state = (!take && allowed) ? irq_pkg::ST_OFFER : irq_pkg::ST_IDLE;
            default:
                nxt_state = irq_pkg::ST_IDLE;
        endcase
    end

    wire load_offer = (nxt_state == irq_pkg::ST_OFFER);

    // ********************************
    // In-service levels
    // ********************************
    wire [3:0] isv_clr = (irq_return_i && isv_any) ? 4'(4'h1 << isv_lvl) : 4'h0;
    wire [3:0] isv_set = take ? 4'(4'h1 << lvl_ff) : 4'h0;

    assign nxt_isv = (isv_ff & ~isv_clr) | isv_set; // [RL4] [RL17]

    // ********************************
    // Wake-up
    // ********************************
    wire wake_pd = power_down_i && |(enabled_req & irq_pkg::WAKE_MASK); // [RL10] [RL18]
    wire wake_idle = idle_i && |enabled_req; // [RL18]

    // ********************************
    // Registers
    // ********************************
    always_ff @(posedge ref_clk_i)
    begin
        if (!rst_n_i)
        begin
            state_ff <= irq_pkg::ST_IDLE;
            src_ff <= irq_pkg::SRC_EXT0;
            lvl_ff <= 2'h0;
            vec_ff <= irq_pkg::VEC_RST;
            isv_ff <= 4'h0;
            wake_ff <= 1'b0;
            hold_req_ff <= 12'h000;
        end
        else if (clk_en_i)
        begin
            state_ff <= nxt_state;
            isv_ff <= nxt_isv;
            wake_ff <= wake_pd || wake_idle;
            hold_req_ff <= pending;
            if (load_offer)
            begin
                src_ff <= win_idx;
                lvl_ff <= win_lvl;
                vec_ff <= irq_pkg::VEC[win_idx]; // [RL8]
            end
        end
    end

    // ********************************
    // Outputs
    // ********************************
    assign irq_req_o = (state_ff == irq_pkg::ST_OFFER);
    assign irq_vector_o = vec_ff;
    assign irq_level_o = lvl_ff;
    assign wake_o = wake_ff;
    assign ext0_request_flag_o = ext_flag[0];
    assign ext1_request_flag_o = ext_flag[1];
    assign in_service_o = isv_ff;

    // ********************************
    // Assertions
    // ********************************
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);

    AST_GLOBAL_OFF: assert property ( // [RL2]
        (clk_en_i && !global_irq_enable) |=> !irq_req_o)
        else $error("request offered with global enable low");

    AST_SRC_ENABLED: assert property ( // [RL1]
        irq_req_o |-> hold_req_ff[src_ff])
        else $error("offered source was not enabled and pending");

    AST_STRICT_PREEMPT: assert property ( // [RL4]
        (irq_req_o && isv_any) |-> (lvl_ff > isv_lvl))
        else $error("offer does not exceed the running level");

    AST_TOP_NEVER: assert property ( // [RL5]
        isv_ff[3] |-> !irq_req_o)
        else $error("offer made while top level in service");

    AST_VECTOR_MATCH: assert property ( // [RL8]
        irq_req_o |-> (irq_vector_o == irq_pkg::VEC[src_ff]))
        else $error("vector does not match offered source");

    AST_EDGE_CLEAR: assert property ( // [RL15]
        (clk_en_i && take && src_ff == irq_pkg::SRC_EXT0 && ext0_edge_select_i && !ext_set[0])
        |=> !ext0_request_flag_o)
        else $error("edge flag not cleared on vectoring");

    AST_WAKE_FILTER: assert property ( // [RL10]
        (clk_en_i && power_down_i && !idle_i && !(|(enabled_req & irq_pkg::WAKE_MASK)))
        |=> !wake_o)
        else $error("non-wake source woke power-down");

    AST_TAKE_LEVEL: assert property ( // [RL4]
        (clk_en_i && take && !irq_return_i) |=> (isv_ff[$past(lvl_ff)] && !irq_req_o))
        else $error("taken level not marked in service");

    COV_EXT0_OFFER: cover property (irq_req_o && src_ff == irq_pkg::SRC_EXT0);
    COV_PREEMPT: cover property (take && isv_any);
    COV_TOP_LEVEL: cover property (isv_ff[3]);
    COV_WAKE_PD: cover property (wake_o && power_down_i);

endmodule : four_level_interrupt_controller

// ### logic/irq_pkg.sv
// Constants and types shared by the interrupt controller files
package irq_pkg;

    // ********************************
    // Sizes and timing
    // ********************************
    localparam int NUM_SRC = 12;
    localparam int LVL_W = 2;
    localparam int IDX_W = 4;
    localparam int VEC_W = 16;
    localparam int NUM_LVL = 4;
    // Machine cycle length in CPU clocks
    localparam int MC_CLKS = 6;
    localparam logic [2:0] MC_CNT_RST = 3'h0;
    localparam logic [2:0] MC_CNT_LAST = 3'(MC_CLKS - 1);

    // ********************************
    // Source indices, in vector order
    // ********************************
    localparam logic [3:0] SRC_EXT0 = 4'h0;
    localparam logic [3:0] SRC_TMR0 = 4'h1;
    localparam logic [3:0] SRC_EXT1 = 4'h2;
    localparam logic [3:0] SRC_TMR1 = 4'h3;
    localparam logic [3:0] SRC_SER = 4'h4;
    localparam logic [3:0] SRC_BO = 4'h5;
    localparam logic [3:0] SRC_TWI = 4'h6;
    localparam logic [3:0] SRC_KB = 4'h7;
    localparam logic [3:0] SRC_CMP2 = 4'h8;
    localparam logic [3:0] SRC_WD = 4'h9;
    localparam logic [3:0] SRC_CMP1 = 4'hA;
    localparam logic [3:0] SRC_BTMR = 4'hB;

    // ********************************
    // Register fields and tables
    // ********************************
    // Enable and priority bit of each source within {reg_b, reg_a}
    localparam logic [3:0] SRC_BIT [NUM_SRC] = '{
        4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h8, 4'h9, 4'hA, 4'h6, 4'hD, 4'hF};
    localparam int GLOBAL_EN_BIT = 7;
    localparam logic [VEC_W-1:0] VEC [NUM_SRC] = '{
        16'h0003, 16'h000B, 16'h0013, 16'h001B, 16'h0023, 16'h002B,
        16'h0033, 16'h003B, 16'h0043, 16'h0053, 16'h0063, 16'h0073};
    // Source index for each tie rank, highest rank first
    localparam logic [3:0] RANK_ORDER [NUM_SRC] = '{
        4'h0, 4'h5, 4'h9, 4'h1, 4'h6, 4'h2, 4'h7, 4'hA, 4'h3, 4'h8, 4'h4, 4'hB};
    localparam logic [NUM_SRC-1:0] WAKE_MASK = 12'h7A5;
    localparam logic [VEC_W-1:0] VEC_RST = 16'h0000;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_OFFER = 2'b10
    } offer_state_e;

endpackage : irq_pkg

// ### test/cpu_ack_model.sv
// Processor-side model that takes each offered vector after a set delay
`timescale 1ns/1ns
module cpu_ack_model
(
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    // Extra ack wait in cycles, zero acks one clock after the offer appears
    input wire logic [3:0] delay_i,
    // Handshake with the controller
    input wire logic irq_req_i,
    output logic irq_ack_o
);
    logic [3:0] wait_ff;

    // Ack is a one-cycle pulse so the offer can never be taken twice
    always_ff @(posedge ref_clk_i)
    begin
        if (!rst_n_i || !irq_req_i || irq_ack_o)
        begin
            wait_ff <= 4'h0;
            irq_ack_o <= 1'b0;
        end
        else if (wait_ff == delay_i)
            irq_ack_o <= 1'b1;
        else
            wait_ff <= wait_ff + 4'h1;
    end
endmodule : cpu_ack_model

// ### test/tb_four_level_interrupt_controller.sv
// Self-checking testbench for the four-level interrupt controller
`timescale 1ns/1ns
module tb_four_level_interrupt_controller;
    logic ref_clk_i;
    logic rst_n_i;
    logic [15:0] en;
    logic [15:0] pl;
    logic [15:0] ph;
    logic [11:0] fl;
    logic [1:0] pin;
    logic rx, es0, es1, ret, idle, pd, ack, req, wake, f0, f1, ce;
    logic [3:0] dly;
    logic [15:0] vec;
    logic [1:0] lvl;
    logic [3:0] insvc;
    int error_cnt;
    int num_checks;

    four_level_interrupt_controller four_level_interrupt_controller_inst
    (
        .ref_clk_i(ref_clk_i),
        .rst_n_i(rst_n_i),
        .clk_en_i(ce),
        .irq_enable_reg_a_i(en[7:0]),
        .irq_enable_reg_b_i(en[15:8]),
        .prio_low_reg_a_i(pl[7:0]),
        .prio_high_reg_a_i(ph[7:0]),
        .prio_low_reg_b_i(pl[15:8]),
        .prio_high_reg_b_i(ph[15:8]),
        .ext0_edge_select_i(es0),
        .ext1_edge_select_i(es1),
        .ext_irq_pin_n_i(pin),
        .timer0_overflow_flag_i(fl[1]),
        .timer1_overflow_flag_i(fl[3]),
        .serial_tx_done_flag_i(fl[4]),
        .serial_rx_done_flag_i(rx),
        .brownout_flag_i(fl[5]),
        .twowire_attention_flag_i(fl[6]),
        .keypad_flag_i(fl[7]),
        .comparator1_flag_i(fl[10]),
        .comparator2_flag_i(fl[8]),
        .watchdog_overflow_flag_i(fl[9]),
        .bus_timer_req_i(fl[11]),
        .irq_ack_i(ack),
        .irq_return_i(ret),
        .irq_req_o(req),
        .irq_vector_o(vec),
        .irq_level_o(lvl),
        .idle_i(idle),
        .power_down_i(pd),
        .wake_o(wake),
        .ext0_request_flag_o(f0),
        .ext1_request_flag_o(f1),
        .in_service_o(insvc)
    );

    cpu_ack_model cpu_ack_model_inst
    (
        .ref_clk_i(ref_clk_i),
        .rst_n_i(rst_n_i),
        .delay_i(dly),
        .irq_req_i(req),
        .irq_ack_o(ack)
    );

    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk_i);
        #1;
    endtask : cyc

    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string nm);
        num_checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("BAD %s exp %h got %h", nm, exp, got);
        end
    endtask : chk

    // Waits for an offer, judges it, then lets the model take it
    task automatic wreq(input logic [15:0] v, input logic [1:0] l);
        int k;
        k = 0;
        while (req !== 1'b1 && k < 60)
        begin
            cyc(1);
            k++;
        end
        chk({15'h0, req}, 16'h1, "offer");
        chk(vec, v, "vector");
        chk({14'h0, lvl}, {14'h0, l}, "level");
        k = 0;
        while (req !== 1'b0 && k < 20)
        begin
            cyc(1);
            k++;
        end
        chk({15'h0, req}, 16'h0, "taken");
    endtask : wreq

    task automatic none();
        cyc(12);
        chk({15'h0, req}, 16'h0, "no offer");
    endtask : none

    task automatic rt();
        ret = 1'b1;
        cyc(1);
        ret = 1'b0;
        cyc(1);
    endtask : rt

    task automatic tally_and_finish();
        if (error_cnt == 0 && num_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : tally_and_finish

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_enable();
        en = 16'h0080;
        fl[1] = 1'b1;
        none();
        en = 16'h0002;
        none();
        // Clock enable low must hold back an otherwise valid offer
        ce = 1'b0;
        en = 16'h0082;
        none();
        ce = 1'b1;
        wreq(16'h000B, 2'h0);
        fl[1] = 1'b0;
        rt();
    endtask : t_enable

    // All peripheral flags but serial receive at once, same level: served strictly by rank
    task automatic t_rank();
        logic [3:0] s;
        en = 16'hA7FF;
        fl = 12'hFFA;
        for (int i = 1; i < 12; i++)
        begin
            s = irq_pkg::RANK_ORDER[i];
            if (s != 4'h2)
            begin
                wreq(irq_pkg::VEC[s], 2'h0);
                fl[s] = 1'b0;
                rt();
            end
        end
        rx = 1'b1;
        wreq(16'h0023, 2'h0);
        rx = 1'b0;
        rt();
    endtask : t_rank

    task automatic t_preempt();
        dly = 4'h4;
        en = 16'h00BA;
        pl = 16'h003A;
        ph = 16'h0030;
        fl[1] = 1'b1;
        fl[4] = 1'b1;
        wreq(16'h0023, 2'h3);
        fl[4] = 1'b0;
        rt();
        wreq(16'h000B, 2'h1);
        chk({12'h0, insvc}, 16'h0002, "in service");
        fl[1] = 1'b0;
        fl[3] = 1'b1;
        none();
        fl[4] = 1'b1;
        wreq(16'h0023, 2'h3);
        chk({12'h0, insvc}, 16'h000A, "nested");
        fl[4] = 1'b0;
        fl[5] = 1'b1;
        none();
        rt();
        wreq(16'h002B, 2'h3);
        fl[5] = 1'b0;
        rt();
        rt();
        wreq(16'h001B, 2'h1);
        fl[3] = 1'b0;
        rt();
        chk({12'h0, insvc}, 16'h0000, "all returned");
        dly = 4'h0;
        pl = 16'h0000;
        ph = 16'h0000;
    endtask : t_preempt

    task automatic t_ext_level();
        en = 16'h0081;
        pin[0] = 1'b0;
        wreq(16'h0003, 2'h0);
        chk({15'h0, f0}, 16'h0001, "level flag");
        rt();
        wreq(16'h0003, 2'h0);
        pin[0] = 1'b1;
        cyc(12);
        chk({15'h0, f0}, 16'h0000, "level flag");
        rt();
    endtask : t_ext_level

    // Both pins fall together in edge mode: external 0 ranks first
    task automatic t_ext_edge();
        es0 = 1'b1;
        es1 = 1'b1;
        en = 16'h0085;
        cyc(12);
        pin = 2'h0;
        wreq(16'h0003, 2'h0);
        cyc(2);
        chk({14'h0, f1, f0}, 16'h0002, "edge flags");
        rt();
        wreq(16'h0013, 2'h0);
        cyc(2);
        chk({14'h0, f1, f0}, 16'h0000, "edge flags");
        rt();
        none();
        pin = 2'h3;
        cyc(12);
        es0 = 1'b0;
    endtask : t_ext_edge

    // Wake does not need the global enable, so no offer disturbs it
    task automatic t_wake();
        en = 16'h0002;
        fl[1] = 1'b1;
        pd = 1'b1;
        cyc(3);
        chk({15'h0, wake}, 16'h0000, "wake timer");
        en = 16'h0202;
        fl[7] = 1'b1;
        cyc(3);
        chk({15'h0, wake}, 16'h0001, "wake keypad");
        fl = 12'h000;
        en = 16'h0001;
        pin[0] = 1'b0;
        cyc(14);
        chk({15'h0, wake}, 16'h0001, "wake ext");
        pd = 1'b0;
        idle = 1'b1;
        cyc(3);
        chk({15'h0, wake}, 16'h0001, "wake idle");
        idle = 1'b0;
        pin[0] = 1'b1;
        en = 16'h0000;
    endtask : t_wake

    // ****************************************
    // Clock, sequence, watchdog
    // ****************************************
    initial
    begin
        ref_clk_i = 1'b0;
        forever #5 ref_clk_i = ~ref_clk_i;
    end

    initial
    begin
        error_cnt = 0;
        num_checks = 0;
        rst_n_i = 1'b0;
        en = 16'h0000;
        pl = 16'h0000;
        ph = 16'h0000;
        fl = 12'h000;
        pin = 2'h3;
        rx = 1'b0;
        es0 = 1'b0;
        es1 = 1'b0;
        ret = 1'b0;
        idle = 1'b0;
        pd = 1'b0;
        dly = 4'h0;
        ce = 1'b1;
        cyc(3);
        rst_n_i = 1'b1;
        chk(vec, 16'h0000, "vector after reset");
        chk({15'h0, req}, 16'h0000, "offer after reset");
        t_enable();
        t_rank();
        t_preempt();
        t_ext_level();
        t_ext_edge();
        t_wake();
        tally_and_finish();
    end

    initial
    begin
        #100000;
        error_cnt++;
        tally_and_finish();
    end
endmodule : tb_four_level_interrupt_controller
